// [include/idmd_pkg.sv]
// Package with the constants and carriers of the internal data memory decoder.
// ****************************************************************
// Operation
// - Three regions: lower RAM, upper RAM, special-function space.
// - Internal addresses are one byte, 256 locations.
// - Above 7FH: direct to special, indirect upper.
// - Upper RAM and special space share 80H-FFH.
// - Lowest 32 bytes form four eight-register banks.
// - Two status-word bits select the register bank.
// - Sixteen bytes above banks hold 128 addressable bits.
// - Lower RAM reachable directly and indirectly.
// - Upper RAM reachable only indirectly.
// - Both halves serve as data and stack.
// - Separate 4096-byte external RAM, byte access.
// - Special registers at x0H/x8H allow bit access.
// - Second data pointer pair, both pairs reset zero.
// - Pointer picked by extended operation bit 0 forms wide data addresses; primary one forms external RAM addresses.
// ****************************************************************
package idmd_pkg;

  // Access kinds issued by the core.
  typedef enum logic [1:0] {
    IDMD_DIRECT,
    IDMD_INDIRECT,
    IDMD_REGISTER,
    IDMD_BIT
  } idmd_mode_e;

  // One request from the core.
  typedef struct packed {
    logic       rd;
    logic       wr;
    idmd_mode_e mode;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       bitVal;
  } idmd_req_s;

  localparam logic [7:0] IDMD_UPPER_BASE = 8'h80;
  localparam logic [7:0] IDMD_BIT_BASE   = 8'h20;
  localparam int         IDMD_RAM_DEPTH  = 256;
  localparam int         IDMD_EXTERNAL_DATA_RAM_DEPTH = 4096;
  localparam int         IDMD_BANK_SHIFT = 3;

  localparam logic [7:0] IDMD_SP_ADDR   = 8'h81;
  localparam logic [7:0] IDMD_DPL_ADDR  = 8'h82;
  localparam logic [7:0] IDMD_DPH_ADDR  = 8'h83;
  localparam logic [7:0] IDMD_ALT_POINTER_LOW_ADDR = 8'h84;
  localparam logic [7:0] IDMD_ALT_POINTER_HIGH_ADDR = 8'h85;
  localparam logic [7:0] IDMD_XSP_ADDR  = 8'h91;
  localparam logic [7:0] IDMD_EXOP_ADDR = 8'ha2;
  localparam logic [7:0] IDMD_PSW_ADDR  = 8'hd0;
  localparam logic [7:0] IDMD_XDAT_ADDR = 8'hf9;

  localparam logic [7:0] IDMD_SP_RST    = 8'h07;
  localparam logic [7:0] IDMD_ZERO_RST  = 8'h00;
  localparam logic [7:0] IDMD_EXOP_MASK = 8'h17;

  localparam int IDMD_PSW_BANK_LO = 3;
  localparam int IDMD_EXOP_DPSEL  = 0;

endpackage

// [rtl/idmd_byte_ram.sv]
// Single-port byte memory with registered read data.
`timescale 1ns/10ps
`default_nettype none
module idmd_byte_ram #(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic          clk,
  input  wire logic          ce,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    rdata
);
  logic [7:0] mem [DEPTH];

  // ****************************************************************
  // Storage
  // ****************************************************************
  // Memory holds no reset; software must initialise what it uses.
  always_ff @(posedge clk)
  begin
    if (ce && we)
    begin
      mem[addr] <= wdata;
    end
  end

  // Read data come from a register, one cycle after the address.
  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      rdata <= mem[addr];
    end
  end
endmodule
`default_nettype wire

// [rtl/idmd_top.sv]
// Internal data memory decoder with special registers and external RAM.
`timescale 1ns/10ps
`default_nettype none
module idmd_top
  import idmd_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  input  wire idmd_pkg::idmd_req_s  req,
  output logic      [7:0]           rdata,
  output logic                      rdBit,
  output logic                      rdValid,
  output logic      [15:0]          dataPointer,
  output logic      [7:0]           stackPointer,
  output logic      [1:0]           bankSel
);
  import idmd_pkg::*;

  logic [7:0]  stack_pointer_ff;
  logic [7:0]  data_pointer_low_ff;
  logic [7:0]  data_pointer_high_ff;
  logic [7:0]  alt_pointer_low_ff;
  logic [7:0]  alt_pointer_high_ff;
  logic [7:0]  extended_stack_pointer_ff;
  logic [7:0]  extended_operation_ff;
  logic [7:0]  program_status_word_ff;
  logic [11:0] xramAddr;
  logic        rdValid_ff;
  logic        rdRam_ff;
  logic        rdXram_ff;
  logic        rdBitMode_ff;
  logic [2:0]  bitIdx_ff;
  logic [7:0]  sfrRdata_ff;
  logic [7:0]  ramRdata;
  logic [7:0]  xramRdata;
  logic [7:0]  ramAddr;
  logic        ramWe;
  logic        ramHit;
  logic        sfrHit;
  logic [7:0]  byteAddr;
  logic [7:0]  sfrRd;
  logic [7:0]  sfrWr;
  logic        xramWe;
  logic        xramHit;
  logic [7:0]  mergeOld;

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  // Bit address to the byte that holds it; 00H-7FH land in RAM 20H-2FH,
  // higher bit addresses land in the special register at x0H or x8H.
  function automatic logic [7:0] bitToByte(input logic [7:0] b);
    if (!b[7])
    begin
      bitToByte = IDMD_BIT_BASE + {4'h0, b[6:3]};
    end
    else
    begin
      bitToByte = {b[7:3], 3'b000};
    end
  endfunction

  // Replace one bit of a byte.
  function automatic logic [7:0] setBit(input logic [7:0] v,
                                        input logic [2:0] i,
                                        input logic       b);
    logic [7:0] r;
    r    = v;
    r[i] = b;
    setBit = r;
  endfunction

  // ****************************************************************
  // Address routing
  // ****************************************************************
  // Register operands fold into the bank chosen by the status word;
  // direct above 7FH goes to special space, indirect to upper RAM.
  always_comb
  begin
    byteAddr = req.addr;
    ramHit   = 1'b0;
    sfrHit   = 1'b0;
    if (req.mode == IDMD_REGISTER)
    begin
      byteAddr = {3'b000, bankSel, req.addr[2:0]};
      ramHit   = 1'b1;
    end
    else if (req.mode == IDMD_BIT)
    begin
      byteAddr = bitToByte(req.addr);
      ramHit   = !req.addr[7];
      sfrHit   = req.addr[7];
    end
    else if (req.addr < IDMD_UPPER_BASE)
    begin
      ramHit = 1'b1;
    end
    else if (req.mode == IDMD_INDIRECT)
    begin
      ramHit = 1'b1;
    end
    else
    begin
      sfrHit = 1'b1;
    end
  end

  // A bit write needs the old byte, which the registered memory read
  // cannot supply this cycle, so RAM bit writes take two core cycles:
  // a read, then a byte write of the merged value issued by the core.
  assign ramAddr = byteAddr;
  assign ramWe   = req.wr && ramHit && (req.mode != IDMD_BIT);

  // Lower and upper halves share one 256-byte array by address.
  idmd_byte_ram #(
    .DEPTH (IDMD_RAM_DEPTH),
    .AW    (8)
  ) u_internal_data_ram (
    .clk   (clk),
    .ce    (ce),
    .we    (ramWe),
    .addr  (ramAddr),
    .wdata (req.wdata),
    .rdata (ramRdata)
  );

  // ****************************************************************
  // External data RAM
  // ****************************************************************
  // The primary pointer's low twelve bits address the external RAM
  // through a data window register.
  assign xramHit = sfrHit && (byteAddr == IDMD_XDAT_ADDR) && !req.mode[0];
  assign xramWe  = req.wr && xramHit;

  // Only twelve pointer bits matter; the top nibble is ignored here.
  assign xramAddr = {data_pointer_high_ff[3:0], data_pointer_low_ff};

  idmd_byte_ram #(
    .DEPTH (IDMD_EXTERNAL_DATA_RAM_DEPTH),
    .AW    (12)
  ) u_external_data_ram (
    .clk   (clk),
    .ce    (ce),
    .we    (xramWe),
    .addr  (xramAddr),
    .wdata (req.wdata),
    .rdata (xramRdata)
  );

  // ****************************************************************
  // Special register read mux
  // ****************************************************************
  always_comb
  begin
    sfrRd = 8'h00;
    if (byteAddr == IDMD_SP_ADDR)
    begin
      sfrRd = stack_pointer_ff;
    end
    else if (byteAddr == IDMD_DPL_ADDR)
    begin
      sfrRd = data_pointer_low_ff;
    end
    else if (byteAddr == IDMD_DPH_ADDR)
    begin
      sfrRd = data_pointer_high_ff;
    end
    else if (byteAddr == IDMD_ALT_POINTER_LOW_ADDR)
    begin
      sfrRd = alt_pointer_low_ff;
    end
    else if (byteAddr == IDMD_ALT_POINTER_HIGH_ADDR)
    begin
      sfrRd = alt_pointer_high_ff;
    end
    else if (byteAddr == IDMD_XSP_ADDR)
    begin
      sfrRd = extended_stack_pointer_ff;
    end
    else if (byteAddr == IDMD_EXOP_ADDR)
    begin
      sfrRd = extended_operation_ff;
    end
    else if (byteAddr == IDMD_PSW_ADDR)
    begin
      sfrRd = program_status_word_ff;
    end
    else
    begin
      sfrRd = 8'h00;
    end
  end

  // Bit writes to special registers are merged here in one cycle.
  always_comb
  begin
    mergeOld = sfrRd;
    sfrWr    = req.wdata;
    if (req.mode == IDMD_BIT)
    begin
      sfrWr = setBit(mergeOld, req.addr[2:0], req.bitVal);
    end
  end

  // ****************************************************************
  // Special registers
  // ****************************************************************
  // Stack pointer and extended stack pointer.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stack_pointer_ff          <= IDMD_SP_RST;
      extended_stack_pointer_ff <= IDMD_ZERO_RST;
    end
    else if (ce && req.wr && sfrHit)
    begin
      if (byteAddr == IDMD_SP_ADDR)
      begin
        stack_pointer_ff <= sfrWr;
      end
      if (byteAddr == IDMD_XSP_ADDR)
      begin
        extended_stack_pointer_ff <= sfrWr;
      end
    end
  end

  // Both data pointer pairs; unknown addresses change nothing.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      data_pointer_low_ff  <= IDMD_ZERO_RST;
      data_pointer_high_ff <= IDMD_ZERO_RST;
      alt_pointer_low_ff   <= IDMD_ZERO_RST;
      alt_pointer_high_ff  <= IDMD_ZERO_RST;
    end
    else if (ce && req.wr && sfrHit)
    begin
      if (byteAddr == IDMD_DPL_ADDR)
      begin
        data_pointer_low_ff <= sfrWr;
      end
      if (byteAddr == IDMD_DPH_ADDR)
      begin
        data_pointer_high_ff <= sfrWr;
      end
      if (byteAddr == IDMD_ALT_POINTER_LOW_ADDR)
      begin
        alt_pointer_low_ff <= sfrWr;
      end
      if (byteAddr == IDMD_ALT_POINTER_HIGH_ADDR)
      begin
        alt_pointer_high_ff <= sfrWr;
      end
    end
  end

  // Status word and extended operation; only implemented bits store.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      program_status_word_ff <= IDMD_ZERO_RST;
      extended_operation_ff  <= IDMD_ZERO_RST;
    end
    else if (ce && req.wr && sfrHit)
    begin
      if (byteAddr == IDMD_PSW_ADDR)
      begin
        program_status_word_ff <= sfrWr;
      end
      if (byteAddr == IDMD_EXOP_ADDR)
      begin
        extended_operation_ff <= sfrWr & IDMD_EXOP_MASK;
      end
    end
  end

  // ****************************************************************
  // Read return
  // ****************************************************************
  // Read source and bit index are kept for the cycle after the strobe.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdValid_ff   <= 1'b0;
      rdRam_ff     <= 1'b0;
      rdXram_ff    <= 1'b0;
      rdBitMode_ff <= 1'b0;
      bitIdx_ff    <= 3'b000;
      sfrRdata_ff  <= 8'h00;
    end
    else if (ce)
    begin
      rdValid_ff   <= req.rd;
      rdRam_ff     <= ramHit;
      rdXram_ff    <= xramHit;
      rdBitMode_ff <= (req.mode == IDMD_BIT);
      bitIdx_ff    <= req.addr[2:0];
      sfrRdata_ff  <= sfrRd;
    end
  end

  // Final data select; RAM data come straight from the memory register.
  always_comb
  begin
    rdata = sfrRdata_ff;
    if (rdRam_ff)
    begin
      rdata = ramRdata;
    end
    else if (rdXram_ff)
    begin
      rdata = xramRdata;
    end
  end

  assign rdBit   = rdBitMode_ff ? rdata[bitIdx_ff] : 1'b0;
  assign rdValid = rdValid_ff;

  // Pointer selected by the extended operation register feeds the core.
  assign dataPointer  = extended_operation_ff[IDMD_EXOP_DPSEL] ?
                        {alt_pointer_high_ff, alt_pointer_low_ff} :
                        {data_pointer_high_ff, data_pointer_low_ff};
  assign stackPointer = stack_pointer_ff;
  assign bankSel      = program_status_word_ff[IDMD_PSW_BANK_LO +: 2];

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_DIRECT_HIGH_SFR: assert property (@(posedge clk) disable iff (rst)
    (req.mode == IDMD_DIRECT && req.addr[7]) |-> !ramWe)
    else $error("Direct high access reached RAM.");
  AST_INDIRECT_RAM: assert property (@(posedge clk) disable iff (rst)
    (req.mode == IDMD_INDIRECT && req.wr) |-> ramWe)
    else $error("Indirect write missed RAM.");
  AST_BANK_ADDR: assert property (@(posedge clk) disable iff (rst)
    (req.mode == IDMD_REGISTER) |-> ramAddr[7:3] == {3'b000, bankSel})
    else $error("Register operand outside active bank.");
  AST_BIT_AREA: assert property (@(posedge clk) disable iff (rst)
    (req.mode == IDMD_BIT && !req.addr[7]) |->
      ramAddr[7:4] == 4'h2)
    else $error("Low bit address outside bit area.");
  AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (rst)
    (ce && req.rd && sfrHit && byteAddr == 8'h94) |=>
      rdata == 8'h00)
    else $error("Reserved read not zero.");
  AST_PSW_BANK: assert property (@(posedge clk) disable iff (rst)
    (ce && req.wr && req.mode == IDMD_DIRECT && req.addr == IDMD_PSW_ADDR)
      |=> bankSel == $past(req.wdata[4:3]))
    else $error("Bank select did not follow status word.");
  AST_ALT_PTR: assert property (@(posedge clk) disable iff (rst)
    (ce && req.wr && req.mode == IDMD_DIRECT && req.addr == IDMD_ALT_POINTER_LOW_ADDR)
      |=> alt_pointer_low_ff == $past(req.wdata))
    else $error("Second pointer low byte not written.");
  AST_EXTERNAL_DATA_RAM_ADDR: assert property (@(posedge clk) disable iff (rst)
    (req.wr && req.mode == IDMD_DIRECT && req.addr == IDMD_XDAT_ADDR)
      |-> xramWe)
    else $error("Window write missed external RAM.");
endmodule
`default_nettype wire

// [test/idmd_core_model.sv]
// Core-side model that issues one-cycle read and write strobes.
`timescale 1ns/10ps
`default_nettype none
module idmd_core_model
  import idmd_pkg::*;
(
  input  wire logic               clk,
  input  wire logic [7:0]         rdata,
  input  wire logic               rdBit,
  input  wire logic               rdValid,
  output var  idmd_pkg::idmd_req_s req
);
  // ****************************************************************
  // Request driving
  // ****************************************************************
  initial req = '0;

  // One strobe cycle, then the idle fields flip so stale values never match.
  task automatic put(input logic rd, input idmd_mode_e m,
                     input logic [7:0] a, input logic [7:0] d,
                     input logic b);
    @(posedge clk);
    req <= '{rd, !rd, m, a, d, b};
    @(posedge clk);
    req <= '{1'b0, 1'b0, idmd_mode_e'(~m), ~a, ~d, ~b};
  endtask

  // Answer is sampled mid-cycle, where it is settled.
  task automatic get(output logic [7:0] v, output logic b,
                     output logic ok);
    @(negedge clk);
    v = rdata;
    b = rdBit;
    ok = rdValid;
  endtask
endmodule
`default_nettype wire

// [test/internal_data_memory_decode_test.sv]
// Self-checking bench for the internal data memory decoder.
`timescale 1ns/10ps
`default_nettype none
module internal_data_memory_decode_test;
  import idmd_pkg::*;
  logic        clk;
  logic        rst;
  logic        ce;
  idmd_req_s   req;
  logic [7:0]  rdata;
  logic [7:0]  stackPointer;
  logic        rdBit;
  logic        rdValid;
  logic [15:0] dataPointer;
  logic [1:0]  bankSel;
  int          failCount;
  int          nCompared;

  // ****************************************************************
  // Design, core model and clock
  // ****************************************************************
  idmd_top u_dut (.clk(clk), .rst(rst), .ce(ce), .req(req),
    .rdata(rdata), .rdBit(rdBit), .rdValid(rdValid),
    .dataPointer(dataPointer), .stackPointer(stackPointer),
    .bankSel(bankSel));
  idmd_core_model u_core (.clk(clk), .rdata(rdata), .rdBit(rdBit),
    .rdValid(rdValid), .req(req));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      failCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input idmd_mode_e m, input logic [7:0] a,
                    input logic [7:0] d, input logic b = 1'b0);
    u_core.put(1'b0, m, a, d, b);
    // Registers update on the edge that ends put; look once settled.
    @(negedge clk);
  endtask

  // A read must answer in the next cycle with data and bit.
  task automatic rdChk(input idmd_mode_e m, input logic [7:0] a,
                       input logic [7:0] e, input logic eb);
    logic [7:0] v;
    logic       b;
    logic       ok;
    u_core.put(1'b1, m, a, 8'h00, 1'b0);
    u_core.get(v, b, ok);
    chk({15'h0, ok}, 16'h0001);
    chk({8'h00, v}, {8'h00, e});
    chk({15'h0, b}, {15'h0, eb});
  endtask

  task automatic stopTest();
    $display("compared %0d mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // A hang ends the run as a mismatch.
  initial
  begin
    repeat (5000) @(posedge clk);
    failCount++;
    stopTest();
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial
  begin
    logic [7:0]  a;
    logic [7:0]  d;
    logic [2:0]  r;
    logic [11:0] xp [4];
    logic [7:0]  xv [4];
    logic [7:0]  ra [8];
    logic [7:0]  rv [8];
    ra = '{IDMD_SP_ADDR, IDMD_DPL_ADDR, IDMD_DPH_ADDR, IDMD_ALT_POINTER_LOW_ADDR,
           IDMD_ALT_POINTER_HIGH_ADDR, IDMD_XSP_ADDR, IDMD_EXOP_ADDR, IDMD_PSW_ADDR};
    rv = '{IDMD_SP_RST, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    void'($urandom(70285));
    rst = 1'b1;
    ce = 1'b1;
    failCount = 0;
    nCompared = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // Register reset values, both pointer pairs zero.
    for (int i = 0; i < 8; i++)
      rdChk(IDMD_DIRECT, ra[i], rv[i], 1'b0);
    chk(dataPointer, 16'h0000);
    // Same address, two storages chosen by mode.
    wr(IDMD_INDIRECT, IDMD_SP_ADDR, 8'ha5);
    rdChk(IDMD_DIRECT, IDMD_SP_ADDR, IDMD_SP_RST, 1'b0);
    rdChk(IDMD_INDIRECT, IDMD_SP_ADDR, 8'ha5, 1'b0);
    wr(IDMD_INDIRECT, IDMD_PSW_ADDR, 8'h5a);
    wr(IDMD_DIRECT, IDMD_PSW_ADDR, 8'h08);
    rdChk(IDMD_INDIRECT, IDMD_PSW_ADDR, 8'h5a, 1'b0);
    chk({14'h0, bankSel}, 16'h0001);
    // Lower half in both modes, upper half indirectly, edges first.
    for (int i = 0; i < 16; i++)
    begin
      a = (i < 2) ? 8'h7f + 8'(i) : 8'($urandom);
      d = 8'($urandom);
      wr((a[7] || i[0]) ? IDMD_INDIRECT : IDMD_DIRECT, a, d);
      rdChk((a[7] || !i[0]) ? IDMD_INDIRECT : IDMD_DIRECT, a, d, 1'b0);
    end
    // Each bank maps register operands into its own eight bytes.
    for (int k = 0; k < 4; k++)
    begin
      wr(IDMD_DIRECT, IDMD_PSW_ADDR, 8'(k << IDMD_PSW_BANK_LO));
      chk({14'h0, bankSel}, 16'(k));
      r = 3'($urandom);
      d = 8'($urandom);
      wr(IDMD_REGISTER, {5'h00, r}, d);
      rdChk(IDMD_INDIRECT, 8'(k * 8) + 8'(r), d, 1'b0);
    end
    // Bit area above the banks, boundary bits included.
    for (int i = 0; i < 6; i++)
    begin
      a = (i == 0) ? 8'h00 : (i == 1) ? 8'h7f : 8'($urandom_range(0, 127));
      d = 8'($urandom);
      wr(IDMD_DIRECT, IDMD_BIT_BASE + 8'(a[6:3]), d);
      rdChk(IDMD_BIT, a, d, d[a[2:0]]);
    end
    // Every bit of the status word, then a single-bit write.
    d = 8'($urandom);
    wr(IDMD_DIRECT, IDMD_PSW_ADDR, d);
    for (int k = 0; k < 8; k++)
      rdChk(IDMD_BIT, IDMD_PSW_ADDR | 8'(k), d, d[k]);
    wr(IDMD_BIT, IDMD_PSW_ADDR | 8'h03, 8'h00, ~d[3]);
    chk({14'h0, bankSel}, {14'h0, d[4], ~d[3]});
    // Enable low freezes state, so this write must not land.
    @(posedge clk) ce <= 1'b0;
    wr(IDMD_DIRECT, IDMD_PSW_ADDR, ~d);
    @(posedge clk) ce <= 1'b1;
    chk({14'h0, bankSel}, {14'h0, d[4], ~d[3]});
    // Reserved place reads zero.
    wr(IDMD_DIRECT, 8'h94, 8'hff);
    rdChk(IDMD_DIRECT, 8'h94, 8'h00, 1'b0);
    // Alternate pointer pair selected through the extended operation.
    wr(IDMD_DIRECT, IDMD_ALT_POINTER_LOW_ADDR, 8'h34);
    wr(IDMD_DIRECT, IDMD_ALT_POINTER_HIGH_ADDR, 8'h12);
    wr(IDMD_DIRECT, IDMD_EXOP_ADDR, 8'hff);
    rdChk(IDMD_DIRECT, IDMD_EXOP_ADDR, IDMD_EXOP_MASK, 1'b0);
    chk(dataPointer, 16'h1234);
    wr(IDMD_DIRECT, IDMD_EXOP_ADDR, 8'h00);
    // External bytes at distinct addresses, top address included.
    for (int i = 0; i < 8; i++)
    begin
      if (i < 4)
      begin
        xp[i] = (i == 3) ? 12'hfff : 12'(i * 1024 + $urandom_range(0, 1023));
        xv[i] = 8'($urandom);
      end
      wr(IDMD_DIRECT, IDMD_DPL_ADDR, xp[i % 4][7:0]);
      wr(IDMD_DIRECT, IDMD_DPH_ADDR, {4'h0, xp[i % 4][11:8]});
      chk(dataPointer, {4'h0, xp[i % 4]});
      if (i < 4)
        wr(IDMD_DIRECT, IDMD_XDAT_ADDR, xv[i]);
      else
        rdChk(IDMD_DIRECT, IDMD_XDAT_ADDR, xv[i % 4], 1'b0);
    end
    // Second reset in mid-run restores the pointers and bank.
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({8'h00, stackPointer}, {8'h00, IDMD_SP_RST});
    chk(dataPointer, 16'h0000);
    chk({14'h0, bankSel}, 16'h0000);
    stopTest();
  end
endmodule
`default_nettype wire
